// *** rtl/dcpwm_pkg.sv ***
// Purpose: shared constants and carriers of the two-channel modulator
// Assumes: 8-bit registers, one per 32-bit bus word
// Notes:   register index times four is the byte address
package dcpwm_pkg;

    localparam int unsigned NCH    = 2;
    localparam int unsigned DW     = 8;
    localparam int unsigned PRE_W  = 7;
    localparam int unsigned CODE_W = 3;
    localparam int unsigned SCL_W  = 9;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned BUS_W  = 32;
    localparam int unsigned IDX_W  = 7;

    // register indices
    localparam logic [IDX_W-1:0] IDX_CTL  = 7'h60;
    localparam logic [IDX_W-1:0] IDX_PRE  = 7'h61;
    localparam logic [IDX_W-1:0] IDX_SCLA = 7'h62;
    localparam logic [IDX_W-1:0] IDX_SCLB = 7'h63;
    localparam logic [IDX_W-1:0] IDX_CNT0 = 7'h64;
    localparam logic [IDX_W-1:0] IDX_CNT1 = 7'h65;
    localparam logic [IDX_W-1:0] IDX_PER0 = 7'h66;
    localparam logic [IDX_W-1:0] IDX_PER1 = 7'h67;
    localparam logic [IDX_W-1:0] IDX_DTY0 = 7'h68;
    localparam logic [IDX_W-1:0] IDX_DTY1 = 7'h69;

    // control field positions
    localparam int unsigned CTL_CAE_LSB  = 6;
    localparam int unsigned CTL_PCLK_LSB = 4;
    localparam int unsigned CTL_POL_LSB  = 2;
    localparam int unsigned CTL_EN_LSB   = 0;

    // prescale field positions and writable bits
    localparam int unsigned PRE_B_LSB = 4;
    localparam int unsigned PRE_A_LSB = 0;
    localparam logic [DW-1:0] PRE_MASK = 8'h77;

    // reset values
    localparam logic [DW-1:0] RST_CTL = 8'h00;
    localparam logic [DW-1:0] RST_PRE = 8'h00;
    localparam logic [DW-1:0] RST_REG = 8'h00;

    // scale value zero stands for full scale
    localparam logic [SCL_W:0] SCL_FULL = 10'h200;

    typedef struct packed {
        logic          en;
        logic          center;
        logic          pol;
        logic          scaled;
        logic [DW-1:0] per;
        logic [DW-1:0] dty;
    } dcpwm_chcfg_s;

endpackage

// *** rtl/dcpwm_clkgen.sv ***
// Purpose: shared prescaler and the two scaled clock dividers
// Assumes: clock ticks are one-cycle enables on clk
// Notes:   index 0 is clock A / SA, index 1 is clock B / SB
`timescale 1ns/10ps
module dcpwm_clkgen (
    input  wire logic                                  clk,
    input  wire logic                                  srst,
    input  wire logic                                  run,
    input  wire logic [1:0][dcpwm_pkg::CODE_W-1:0]     code,
    input  wire logic [1:0][dcpwm_pkg::DW-1:0]         scl,
    input  wire logic [1:0]                            scl_wr,
    output logic      [1:0]                            tick_pre,
    output logic      [1:0]                            tick_scl
);
    typedef struct packed {
        logic [dcpwm_pkg::PRE_W-1:0]      pre;
        logic [1:0][dcpwm_pkg::SCL_W-1:0] sc;
    } dcpwm_cg_s;

    dcpwm_cg_s st_q;
    dcpwm_cg_s st_d;
    logic [1:0][dcpwm_pkg::PRE_W-1:0] mask;
    logic [1:0][dcpwm_pkg::SCL_W:0]   lim;

    always_comb begin
        st_d = st_q;
        // counter clears and holds at zero while both channels are off, saving power
        st_d.pre = run ? st_q.pre + 1'b1 : '0;
        for (int k = 0; k < 2; k++) begin
            mask[k] = ~(7'h7f << code[k]);
            tick_pre[k] = run && ((st_q.pre & mask[k]) == mask[k]);
            lim[k] = (scl[k] == '0) ? dcpwm_pkg::SCL_FULL : {1'b0, scl[k], 1'b0};
            tick_scl[k] = tick_pre[k] && ({1'b0, st_q.sc[k]} == lim[k] - 1'b1);
            if (scl_wr[k]) begin
                st_d.sc[k] = '0;
            end else if (tick_pre[k]) begin
                st_d.sc[k] = tick_scl[k] ? '0 : st_q.sc[k] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// *** rtl/dcpwm_chan.sv ***
// Purpose: one modulator channel: counter, double buffers, compare
// Assumes: tick is a one-cycle enable of the selected channel clock
// Notes:   output is low while the channel is disabled
`timescale 1ns/10ps
module dcpwm_chan (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        tick,
    input  wire dcpwm_pkg::dcpwm_chcfg_s     cfg,
    input  wire logic                        cnt_wr,
    output logic [dcpwm_pkg::DW-1:0]         cnt,
    output logic                             wave
);
    typedef struct packed {
        logic                     run;
        logic                     down;
        logic                     phase;
        logic [dcpwm_pkg::DW-1:0] cnt;
        logic [dcpwm_pkg::DW-1:0] per;
        logic [dcpwm_pkg::DW-1:0] dty;
    } dcpwm_ch_s;

    dcpwm_ch_s st_q;
    dcpwm_ch_s st_d;

    always_comb begin
        st_d = st_q;
        if (!cfg.en) begin
            st_d.run = 1'b0;
            st_d.per = cfg.per;
            st_d.dty = cfg.dty;
        end else if (tick) begin
            st_d.run = 1'b1;
        end
        if (cnt_wr) begin
            st_d.cnt   = '0;
            st_d.down  = 1'b0;
            st_d.phase = 1'b0;
            st_d.per   = cfg.per;
            st_d.dty   = cfg.dty;
        end else if (cfg.en && st_q.run && tick) begin
            if (!cfg.center) begin
                // left aligned: 0 .. period-1
                if ({1'b0, st_q.cnt} + 9'h001 >= {1'b0, st_q.per}) begin
                    st_d.cnt   = '0;
                    st_d.phase = 1'b0;
                    st_d.per   = cfg.per;
                    st_d.dty   = cfg.dty;
                end else begin
                    st_d.cnt = st_q.cnt + 1'b1;
                end
                if (st_d.cnt == st_d.dty) begin
                    st_d.phase = 1'b1;
                end
            end else begin
                // center aligned: up to period, back down to 0
                if (!st_q.down) begin
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_d.cnt >= st_q.per) begin
                        st_d.down = 1'b1;
                    end
                end else if (st_q.cnt <= 8'h01) begin
                    st_d.cnt   = '0;
                    st_d.down  = 1'b0;
                    st_d.phase = 1'b0;
                    st_d.per   = cfg.per;
                    st_d.dty   = cfg.dty;
                end else begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end
                if (st_d.cnt == st_d.dty && st_d.cnt != '0) begin
                    st_d.phase = ~st_q.down;
                end
            end
        end
        cnt = st_q.cnt;
        // polarity applied live; a change mid-period may bend one pulse
        wave = st_q.run && (cfg.pol ^ st_q.phase);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// *** rtl/dcpwm_top.sv ***
// Purpose: two-channel 8-bit modulator with Avalon-MM register slave
// Assumes: all logic on the interface clock, synchronous reset
// Notes:   one wait state on every access; byte lane 0 carries data
// Function
// - reserved bits read zero and ignore writes
// - control bits 7 and 6 pick center (1) or left (0) alignment
// - control bit 5 picks clock B or scaled SB for channel 1
// - control bit 4 picks clock A or scaled SA for channel 0
// - polarity bits 3..2 give starting level; output flips at duty match
// - enable bits 1..0; waveform starts at next channel clock tick
// - prescaler counter stops while both channels are disabled
// - polarity writes accepted anytime and applied directly
// - clock select writes accepted anytime and applied directly
// - prescale bits 6..4 divide clock B by 2 to the code
// - prescale bits 2..0 set clock A; bits 7 and 3 unused
// - control and prescale registers reset to zero
// - all timing derives from the interface clock
// - scaled clock is source divided by twice scale; zero means 256
// - left counts 0..period-1; center counts up to period and down
// - duty equal to counter changes the output state
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
module dcpwm_top (
    input  wire logic                             clk,
    input  wire logic                             srst,
    input  wire logic [dcpwm_pkg::ADDR_W-1:0]     avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [dcpwm_pkg::BUS_W-1:0]      avs_writedata,
    input  wire logic [3:0]                       avs_byteenable,
    output logic      [dcpwm_pkg::BUS_W-1:0]      avs_readdata,
    output logic                                  avs_waitrequest,
    output logic                                  waveform_out_0,
    output logic                                  waveform_out_1
);

    typedef struct packed {
        logic                                 ack;
        logic [dcpwm_pkg::DW-1:0]             ctl;
        logic [dcpwm_pkg::DW-1:0]             pre;
        logic [1:0][dcpwm_pkg::DW-1:0]        scl;
        logic [1:0][dcpwm_pkg::DW-1:0]        per;
        logic [1:0][dcpwm_pkg::DW-1:0]        dty;
        logic [dcpwm_pkg::DW-1:0]             rdata;
        logic [1:0]                           wout;
    } dcpwm_top_s;

    dcpwm_top_s st_q;
    dcpwm_top_s st_d;

    logic [dcpwm_pkg::IDX_W-1:0]          idx;
    logic                                 hit;
    logic                                 wr_go;
    logic [dcpwm_pkg::DW-1:0]             wbyte;
    logic [1:0]                           scl_wr;
    logic [1:0]                           cnt_wr;
    logic [1:0][dcpwm_pkg::CODE_W-1:0]    code;
    logic [1:0]                           tick_pre;
    logic [1:0]                           tick_scl;
    logic [1:0]                           tick_ch;
    logic [1:0][dcpwm_pkg::DW-1:0]        ch_cnt;
    logic [1:0]                           ch_wave;
    dcpwm_pkg::dcpwm_chcfg_s [1:0]        cfg;
    logic                                 pre_run;

    // read multiplexer; unmapped words read zero
    function automatic logic [dcpwm_pkg::DW-1:0] reg_read(
        input logic [dcpwm_pkg::IDX_W-1:0]   i,
        input dcpwm_top_s                    s,
        input logic [1:0][dcpwm_pkg::DW-1:0] c
    );
        logic [dcpwm_pkg::DW-1:0] v;
        v = '0;
        unique case (i)
            dcpwm_pkg::IDX_CTL:  v = s.ctl;
            dcpwm_pkg::IDX_PRE:  v = s.pre & dcpwm_pkg::PRE_MASK;
            dcpwm_pkg::IDX_SCLA: v = s.scl[0];
            dcpwm_pkg::IDX_SCLB: v = s.scl[1];
            dcpwm_pkg::IDX_CNT0: v = c[0];
            dcpwm_pkg::IDX_CNT1: v = c[1];
            dcpwm_pkg::IDX_PER0: v = s.per[0];
            dcpwm_pkg::IDX_PER1: v = s.per[1];
            dcpwm_pkg::IDX_DTY0: v = s.dty[0];
            dcpwm_pkg::IDX_DTY1: v = s.dty[1];
            default:             v = '0;
        endcase
        return v;
    endfunction

    assign idx   = avs_address[dcpwm_pkg::ADDR_W-1:2];
    assign hit   = avs_read | avs_write;
    // a write lands on the edge where waitrequest is seen low
    assign wr_go = avs_write & st_q.ack & avs_byteenable[0];
    assign wbyte = avs_writedata[dcpwm_pkg::DW-1:0];

    assign scl_wr[0] = wr_go && (idx == dcpwm_pkg::IDX_SCLA);
    assign scl_wr[1] = wr_go && (idx == dcpwm_pkg::IDX_SCLB);
    assign cnt_wr[0] = wr_go && (idx == dcpwm_pkg::IDX_CNT0);
    assign cnt_wr[1] = wr_go && (idx == dcpwm_pkg::IDX_CNT1);

    always_comb begin
        st_d = st_q;
        st_d.ack = hit & ~st_q.ack;
        if (hit && !st_q.ack) begin
            st_d.rdata = reg_read(idx, st_q, ch_cnt);
        end
        if (wr_go) begin
            unique case (idx)
                dcpwm_pkg::IDX_CTL: begin
                    st_d.ctl = wbyte;
                end
                dcpwm_pkg::IDX_PRE: begin
                    st_d.pre = wbyte & dcpwm_pkg::PRE_MASK;
                end
                dcpwm_pkg::IDX_SCLA: begin
                    st_d.scl[0] = wbyte;
                end
                dcpwm_pkg::IDX_SCLB: begin
                    st_d.scl[1] = wbyte;
                end
                dcpwm_pkg::IDX_PER0: begin
                    st_d.per[0] = wbyte;
                end
                dcpwm_pkg::IDX_PER1: begin
                    st_d.per[1] = wbyte;
                end
                dcpwm_pkg::IDX_DTY0: begin
                    st_d.dty[0] = wbyte;
                end
                dcpwm_pkg::IDX_DTY1: begin
                    st_d.dty[1] = wbyte;
                end
                // counters are written through cnt_wr; others unmapped
                default: begin
                    st_d.ctl = st_q.ctl;
                end
            endcase
        end
        // registered so the outputs come straight from flops
        st_d.wout = ch_wave;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q       <= '0;
            st_q.ctl   <= dcpwm_pkg::RST_CTL;
            st_q.pre   <= dcpwm_pkg::RST_PRE;
            st_q.scl   <= {2{dcpwm_pkg::RST_REG}};
            st_q.per   <= {2{dcpwm_pkg::RST_REG}};
            st_q.dty   <= {2{dcpwm_pkg::RST_REG}};
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata    = {{(dcpwm_pkg::BUS_W-dcpwm_pkg::DW){1'b0}}, st_q.rdata};
    assign avs_waitrequest = ~st_q.ack;
    assign waveform_out_0  = st_q.wout[0];
    assign waveform_out_1  = st_q.wout[1];

    // prescaler runs only while some channel is enabled
    assign pre_run = |st_q.ctl[dcpwm_pkg::CTL_EN_LSB +: 2];

    assign code[0] = st_q.pre[dcpwm_pkg::PRE_A_LSB +: dcpwm_pkg::CODE_W];
    assign code[1] = st_q.pre[dcpwm_pkg::PRE_B_LSB +: dcpwm_pkg::CODE_W];

    dcpwm_clkgen u_clkgen (
        .clk      (clk),
        .srst     (srst),
        .run      (pre_run),
        .code     (code),
        .scl      (st_q.scl),
        .scl_wr   (scl_wr),
        .tick_pre (tick_pre),
        .tick_scl (tick_scl)
    );

    for (genvar g = 0; g < dcpwm_pkg::NCH; g++) begin : g_ch
        always_comb begin
            cfg[g].en     = st_q.ctl[dcpwm_pkg::CTL_EN_LSB + g];
            cfg[g].center = st_q.ctl[dcpwm_pkg::CTL_CAE_LSB + g];
            cfg[g].pol    = st_q.ctl[dcpwm_pkg::CTL_POL_LSB + g];
            cfg[g].scaled = st_q.ctl[dcpwm_pkg::CTL_PCLK_LSB + g];
            cfg[g].per    = st_q.per[g];
            cfg[g].dty    = st_q.dty[g];
        end

        // clock select switches at once; one bent pulse is accepted
        assign tick_ch[g] = cfg[g].scaled ? tick_scl[g] : tick_pre[g];

        dcpwm_chan u_chan (
            .clk    (clk),
            .srst   (srst),
            .tick   (tick_ch[g]),
            .cfg    (cfg[g]),
            .cnt_wr (cnt_wr[g]),
            .cnt    (ch_cnt[g]),
            .wave   (ch_wave[g])
        );
    end

endmodule

// *** test/dcpwm_assertions.sv ***
// Purpose: bus and output checks of the two-channel modulator
// Assumes: sees only top ports; shadows control and prescale
// Notes:   five-cycle bound covers the two-stage output path
`timescale 1ns/10ps
module dcpwm_assertions (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [8:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        waveform_out_0,
    input wire logic        waveform_out_1
);
    logic [6:0] idx;
    logic [7:0] ctl_q;
    logic [7:0] pre_q;
    logic       wr_ok;
    assign idx   = avs_address[8:2];
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_q <= 8'h00;
            pre_q <= 8'h00;
        end else begin
            if (wr_ok && idx == dcpwm_pkg::IDX_CTL) ctl_q <= avs_writedata[7:0];
            if (wr_ok && idx == dcpwm_pkg::IDX_PRE) pre_q <= avs_writedata[7:0] & 8'h77;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_first;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd(logic [6:0] i);
        avs_read && avs_waitrequest && idx == i;
    endsequence
    property p_ack; s_first |=> !avs_waitrequest; endproperty
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_idle; !$past(avs_read) && !$past(avs_write) |-> avs_waitrequest; endproperty
    property p_upper; avs_readdata[31:8] == 24'h00_0000; endproperty
    property p_ctl; s_rd(dcpwm_pkg::IDX_CTL) |=> avs_readdata[7:0] == $past(ctl_q); endproperty
    property p_pre; s_rd(dcpwm_pkg::IDX_PRE) |=> avs_readdata[7:0] == $past(pre_q); endproperty
    property p_gap;
        avs_read && avs_waitrequest && (idx < 7'h60 || idx > 7'h69) |=> avs_readdata == 32'h0000_0000;
    endproperty
    property p_off0; !ctl_q[0] [*5] |-> !waveform_out_0; endproperty
    property p_off1; !ctl_q[1] [*5] |-> !waveform_out_1; endproperty
    a_ack:   assert property (p_ack) else $error("no answer after one wait state");
    a_one:   assert property (p_one) else $error("waitrequest low for more than a cycle");
    a_idle:  assert property (p_idle) else $error("waitrequest low without request");
    a_upper: assert property (p_upper) else $error("read data upper bits not zero");
    a_ctl:   assert property (p_ctl) else $error("control read mismatch");
    a_pre:   assert property (p_pre) else $error("prescale read mismatch");
    a_gap:   assert property (p_gap) else $error("unmapped read not zero");
    a_off0:  assert property (p_off0) else $error("channel 0 output while disabled");
    a_off1:  assert property (p_off1) else $error("channel 1 output while disabled");
endmodule
bind dcpwm_top dcpwm_assertions u_chk (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .waveform_out_0(waveform_out_0), .waveform_out_1(waveform_out_1));

// *** test/dcpwm_drv_model.sv ***
// Purpose: behavioural view of the output drivers on both waveforms
// Assumes: waveforms are registered levels sampled on clk
// Notes:   reports last full period and high time in clk cycles
`timescale 1ns/10ps
module dcpwm_drv_model (
    input  wire logic        clk,
    input  wire logic [1:0]  wave,
    output logic [1:0][15:0] per,
    output logic [1:0][15:0] hi,
    output logic [1:0][7:0]  rises
);
    logic [1:0]       wave_q = 2'b00;
    logic [1:0][15:0] cnt    = '0;
    logic [1:0][15:0] hcnt   = '0;
    initial begin
        per = '0;
        hi = '0;
        rises = '0;
    end
    always @(posedge clk) begin
        for (int k = 0; k < 2; k++) begin
            wave_q[k] <= wave[k];
            hcnt[k] <= wave[k] ? 16'(hcnt[k] + 1) : 16'h0000;
            cnt[k] <= (wave[k] && !wave_q[k]) ? 16'h0000 : 16'(cnt[k] + 1);
            if (wave[k] && !wave_q[k]) begin
                per[k] <= 16'(cnt[k] + 1);
                rises[k] <= 8'(rises[k] + 1);
            end
            if (!wave[k] && wave_q[k]) hi[k] <= hcnt[k];
        end
    end
endmodule

// *** test/test_dual_channel_pwm_control.sv ***
// Purpose: self-checking bench of the two-channel modulator
// Assumes: one wait state bus; waveforms measured by the driver model
// Notes:   periods kept small so each test stays short
`timescale 1ns/10ps
module test_dual_channel_pwm_control;
    logic             clk            = 1'b0;
    logic             srst           = 1'b1;
    logic [8:0]       avs_address    = 9'h000;
    logic             avs_read       = 1'b0;
    logic             avs_write      = 1'b0;
    logic [31:0]      avs_writedata  = 32'h0000_0000;
    logic [3:0]       avs_byteenable = 4'h1;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic [1:0]       wave;
    logic [1:0][15:0] m_per;
    logic [1:0][15:0] m_hi;
    logic [1:0][7:0]  m_rise;
    logic [7:0]       q;
    int               errors         = 0;
    int               n_checks       = 0;
    int               cyc            = 0;
    always #2.5 clk = ~clk;
    dcpwm_top DUT (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .waveform_out_0(wave[0]), .waveform_out_1(wave[1]));
    dcpwm_drv_model u_drv (.clk(clk), .wave(wave), .per(m_per), .hi(m_hi), .rises(m_rise));
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (e !== s) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d);
        int t = 0;
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= {i, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        // sampled on the rising edge, before that edge updates the slave
        do begin
            @(posedge clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 40);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (t >= 40) begin
            errors++;
            summarize();
        end
    endtask
    function automatic logic [15:0] span(bit ctr, int div, int n);
        return 16'((ctr ? 2 : 1) * div * n);
    endfunction
    task automatic run(input int ch, input int code, input bit ctr, input bit sc, input bit pol, input int s);
        logic [7:0] per, dty, cv;
        int div, r, t;
        per = 8'(2 + $urandom % 5);
        dty = 8'(1 + $urandom % (per - 1));
        div = (1 << code) * (sc ? 2 * (s == 0 ? 256 : s) : 1);
        cv = 8'((ctr << 6 | sc << 4 | pol << 2 | 1) << ch);
        bus(1, dcpwm_pkg::IDX_CTL, 8'h00);
        bus(1, dcpwm_pkg::IDX_PRE, 8'(code * 17) | 8'h88);
        bus(0, dcpwm_pkg::IDX_PRE, 8'h00);
        chk("prescale", 16'(code * 17), q);
        bus(1, 7'(dcpwm_pkg::IDX_SCLA + ch), 8'(s));
        bus(1, 7'(dcpwm_pkg::IDX_PER0 + ch), per);
        bus(1, 7'(dcpwm_pkg::IDX_DTY0 + ch), dty);
        bus(1, 7'(dcpwm_pkg::IDX_CNT0 + ch), 8'h00);
        bus(0, 7'(dcpwm_pkg::IDX_CNT0 + ch), 8'h00);
        chk("counter", 16'h0000, q);
        bus(1, dcpwm_pkg::IDX_CTL, cv);
        bus(0, dcpwm_pkg::IDX_CTL, 8'h00);
        chk("control", cv, q);
        r = m_rise[ch];
        t = 0;
        // full-scale scaled clock needs several thousand cycles per period
        while (8'(m_rise[ch] - r) < 3 && t < 20000) begin
            @(posedge clk);
            t++;
        end
        if (t >= 20000) begin
            errors++;
            $display("[ERR] rises expected 3 seen %0d", 8'(m_rise[ch] - r));
            summarize();
        end
        chk("period", span(ctr, div, per), m_per[ch]);
        chk("high", span(ctr, div, pol ? dty : per - dty), m_hi[ch]);
        $display("test ch %0d code %0d center %0d scaled %0d done", ch, code, ctr, sc);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        void'($urandom(82097));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        bus(0, dcpwm_pkg::IDX_CTL, 8'h00);
        chk("control reset", 16'h0000, q);
        bus(0, dcpwm_pkg::IDX_PRE, 8'h00);
        chk("prescale reset", 16'h0000, q);
        bus(1, 7'h10, 8'hA5);
        bus(0, 7'h10, 8'h00);
        chk("unmapped", 16'h0000, q);
        bus(1, dcpwm_pkg::IDX_DTY1, 8'h5A);
        avs_byteenable <= 4'h0;
        bus(1, dcpwm_pkg::IDX_DTY1, 8'h33);
        avs_byteenable <= 4'h1;
        bus(0, dcpwm_pkg::IDX_DTY1, 8'h00);
        chk("byte enable", 16'h005A, q);
        for (int c = 0; c < 8; c++) begin
            run(0, c, 1'b0, 1'b0, 1'($urandom), 1);
            run(1, c, 1'b0, 1'b0, 1'($urandom), 1);
        end
        repeat (6) run($urandom % 2, $urandom % 3, 1'($urandom), 1'b1, 1'($urandom), 1 + $urandom % 3);
        run(0, 0, 1'b0, 1'b1, 1'b1, 0);
        summarize();
    end
endmodule
